/* File: pkg/apa_pkg.sv */
package apa_pkg;
    // byte lane width of the peripheral data path
    localparam int DATA_W = 8;
    // address width of the processor bus (byte addresses)
    localparam int ADDR_W = 24;
    // example peripheral base addresses
    localparam logic [23:0] LINK_BASE = 24'h018001;
    localparam logic [23:0] TIMER_BASE = 24'h018801;
    // decoder select inputs, msb first: addr[11], addr[12], addr[0]; window bits 23:14
    // only odd bytes are used, so bit 0 puts both examples on odd lines (one and five)
    localparam int DEC_SEL2 = 11;
    localparam int DEC_SEL1 = 12;
    localparam int DEC_SEL0 = 0;
    localparam int WIN_LO = 14;
    localparam logic [9:0] WIN_VALUE = 10'h006;
    // reset values of the two acknowledge-path flops
    localparam logic SEL_RST = 1'b0;
    localparam logic ACK_RST = 1'b0;
    // synchroniser depth (cycles)
    localparam int SYNC_STAGES = 2;
    // access phases
    typedef enum logic [2:0] {
        APA_IDLE = 3'b001,
        APA_SEL = 3'b010,
        APA_ACK = 3'b100
    } apa_state_t;
endpackage : apa_pkg

/* File: design/apa_byte_latch.sv */
`timescale 1ns/1ps
// one byte holding register standing in for a transparent latch:
// follows its input while open, keeps the last value once closed
module apa_byte_latch #(
    parameter int WIDTH = 8 // data width
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic open, // high: transparent
    input wire logic [WIDTH-1:0] din, // data in
    output logic [WIDTH-1:0] dout // held data, registered
);
    // a real latch is avoided; one cycle of lag is the price of a clean timing path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else if (open) begin
            dout <= din;
        end
    end
endmodule : apa_byte_latch

/* File: design/apa_adapter.sv */
`timescale 1ns/1ps
module apa_adapter
    import apa_pkg::*;
#(
    parameter int WIDTH = apa_pkg::DATA_W // byte lane width
) (
    input wire logic clk, // system clock, 200 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic byteStrobe, // processor data strobe, high = active
    input wire logic sysSelect, // system peripheral select, high = active
    input wire logic readNotWrite, // 1 read, 0 write
    input wire logic periphEnable, // peripheral enable clock, sampled
    input wire logic [apa_pkg::ADDR_W-1:0] addr, // processor byte address
    input wire logic [WIDTH-1:0] cpuDataIn, // processor data bus, input
    output logic [WIDTH-1:0] cpuDataOut, // processor data bus, output
    output logic cpuDataOe, // processor data bus drive enable
    input wire logic [WIDTH-1:0] perDataIn, // peripheral data bus, input
    output logic [WIDTH-1:0] perDataOut, // peripheral data bus, output
    output logic perDataOe, // peripheral data bus drive enable
    output logic transferAckN, // transfer acknowledge, active low
    output logic periphSelectN, // common peripheral select, active low
    output logic timerSelLowN, // timer low select, active low
    output logic timerSelHigh, // timer high select
    output logic linkSelN // link controller select, active low
);
    import apa_pkg::*;

    logic [SYNC_STAGES-1:0] strobeSync_ff;
    logic [SYNC_STAGES-1:0] selSync_ff;
    logic [SYNC_STAGES-1:0] rwSync_ff;
    logic [SYNC_STAGES-1:0] enSync_ff;
    logic enPrev_ff;
    logic strobeS, selS, rwS, enFall;
    apa_state_t state_ff, nxt_state;
    logic selectFlop, ackFlop;
    logic readDir, latchOpen;
    logic [WIDTH-1:0] readHeld, writeHeld;
    logic [7:0] decoderLine;
    logic decoderLineFive, decoderLineOne;

    // active-low 1-of-8 decoder over address bits 11, 12 and 0, windowed
    function automatic logic [7:0] dec_lines(input logic [ADDR_W-1:0] a);
        logic [7:0] l;
        l = 8'hFF;
        if (a[ADDR_W-1:WIN_LO] == WIN_VALUE) begin
            l[{a[DEC_SEL2], a[DEC_SEL1], a[DEC_SEL0]}] = 1'b0;
        end
        return l;
    endfunction : dec_lines

    // two-stage synchronisers; only the last stage is looked at
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeSync_ff <= '0;
            selSync_ff <= '0;
            rwSync_ff <= '0;
            enSync_ff <= '0;
        end else begin
            strobeSync_ff <= {strobeSync_ff[0], byteStrobe};
            selSync_ff <= {selSync_ff[0], sysSelect};
            rwSync_ff <= {rwSync_ff[0], readNotWrite};
            enSync_ff <= {enSync_ff[0], periphEnable};
        end
    end

    assign strobeS = strobeSync_ff[SYNC_STAGES-1];
    assign selS = selSync_ff[SYNC_STAGES-1];
    assign rwS = rwSync_ff[SYNC_STAGES-1];

    // enable edge detector, reads only the settled stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enPrev_ff <= 1'b0;
        end else begin
            enPrev_ff <= enSync_ff[SYNC_STAGES-1];
        end
    end
    assign enFall = enPrev_ff & ~enSync_ff[SYNC_STAGES-1];

    // select/ack sequencing: flops only move on enable falling edges,
    // but strobe negation clears them at once
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            APA_IDLE: begin
                if (enFall && strobeS && selS) begin
                    nxt_state = APA_SEL;
                end
            end
            APA_SEL: begin
                if (!strobeS) begin
                    nxt_state = APA_IDLE;
                end else if (enFall) begin
                    nxt_state = APA_ACK;
                end
            end
            APA_ACK: begin
                if (!strobeS) begin
                    nxt_state = APA_IDLE;
                end
            end
            default: nxt_state = APA_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= APA_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // flop views: select flop stays set until strobe ends, like the circuit
    assign selectFlop = (state_ff == APA_SEL) || (state_ff == APA_ACK);
    assign ackFlop = (state_ff == APA_ACK);
    assign transferAckN = ~ackFlop;
    assign periphSelectN = ~(selectFlop & ~ackFlop);

    // latch direction from system select and rw alone
    assign readDir = selS & rwS;
    assign latchOpen = ~ackFlop; // frozen while ack is low
    assign cpuDataOe = readDir;
    assign perDataOe = ~readDir;

    // read path: peripheral to processor
    apa_byte_latch #(
        .WIDTH(WIDTH)
    ) u_read_latch (
        .clk(clk),
        .rst_n(rst_n),
        .open(latchOpen & readDir),
        .din(perDataIn),
        .dout(readHeld)
    );

    // write path: processor to peripheral
    apa_byte_latch #(
        .WIDTH(WIDTH)
    ) u_write_latch (
        .clk(clk),
        .rst_n(rst_n),
        .open(latchOpen & ~readDir),
        .din(cpuDataIn),
        .dout(writeHeld)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuDataOut <= '0;
            perDataOut <= '0;
        end else begin
            cpuDataOut <= readHeld;
            perDataOut <= writeHeld;
        end
    end

    // example address decoding for two peripherals
    assign decoderLine = dec_lines(addr);
    assign decoderLineFive = decoderLine[5]; // high when not at 18801 window
    assign decoderLineOne = decoderLine[1];
    assign timerSelLowN = decoderLineFive;
    assign timerSelHigh = ~periphSelectN;
    assign linkSelN = ~(decoderLineFive & ~decoderLineOne & ~periphSelectN);

    // assertions
    property p_idle_ack_high;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == APA_IDLE) |-> transferAckN && periphSelectN &&
            (perDataOe || (selS && rwS));
    endproperty
    a_idle_ack_high: assert property (p_idle_ack_high)
        else $error("ack not high while idle");

    property p_write_drives;
        @(posedge clk) disable iff (!rst_n)
        !$past(readNotWrite, 2) |-> perDataOe && !cpuDataOe;
    endproperty
    a_write_drives: assert property (p_write_drives)
        else $error("write path not driving on write");

    property p_read_dir;
        @(posedge clk) disable iff (!rst_n)
        ($past(readNotWrite, 2) && $past(sysSelect, 2)) |-> cpuDataOe && !perDataOe;
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("read direction wrong");

    property p_sel_on_fall;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == APA_IDLE && enFall && strobeS && selS) |=> !periphSelectN;
    endproperty
    a_sel_on_fall: assert property (p_sel_on_fall)
        else $error("select missed enable falling edge");

    property p_sel_only_on_fall;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == APA_IDLE && !enFall) |=> periphSelectN;
    endproperty
    a_sel_only_on_fall: assert property (p_sel_only_on_fall)
        else $error("select without enable falling edge");

    property p_ack_after_sel;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == APA_SEL && strobeS && enFall) |=> !transferAckN;
    endproperty
    a_ack_after_sel: assert property (p_ack_after_sel)
        else $error("ack not asserted on next falling edge");

    property p_ack_deselects;
        @(posedge clk) disable iff (!rst_n)
        $fell(transferAckN) |-> periphSelectN && $past(!periphSelectN);
    endproperty
    a_ack_deselects: assert property (p_ack_deselects)
        else $error("peripheral selected while ack low");

    property p_strobe_clears;
        @(posedge clk) disable iff (!rst_n)
        (!strobeS && state_ff != APA_IDLE) |=> transferAckN && periphSelectN;
    endproperty
    a_strobe_clears: assert property (p_strobe_clears)
        else $error("strobe end did not clear flops");

    property p_frozen;
        @(posedge clk) disable iff (!rst_n)
        (!transferAckN && $past(!transferAckN)) |-> $stable(readHeld) && $stable(writeHeld);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("latch changed while ack low");

    c_read: cover property (@(posedge clk) disable iff (!rst_n)
        !transferAckN && cpuDataOe);
    c_write: cover property (@(posedge clk) disable iff (!rst_n)
        !transferAckN && perDataOe);
    c_abort: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff == APA_SEL && !strobeS);
endmodule : apa_adapter

/* File: bench/apa_cpu_model.sv */
`timescale 1ns/1ps
// processor side master: raises strobe, holds it until ack low or a bounded wait runs out, then drops
module apa_cpu_model
    import apa_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic start, // one-cycle request
    input wire logic rd, // 1 read
    input wire logic useSel, // drive system select
    input wire logic [apa_pkg::ADDR_W-1:0] a, // byte address
    input wire logic [apa_pkg::DATA_W-1:0] wd, // write data
    input wire logic transferAckN, // ack, active low
    input wire logic [apa_pkg::DATA_W-1:0] cpuDataOut, // read data
    output logic byteStrobe, // strobe
    output logic sysSelect, // system select
    output logic readNotWrite, // rw
    output logic [apa_pkg::ADDR_W-1:0] addr, // address
    output logic [apa_pkg::DATA_W-1:0] cpuDataIn, // write data
    output logic [apa_pkg::DATA_W-1:0] rdData, // read data taken at ack
    output logic busy // access in flight
);
    int waitCnt;
    initial begin
        {byteStrobe, sysSelect, readNotWrite, busy} = 4'h0;
        addr = 24'h000000;
        cpuDataIn = 8'h00;
        rdData = 8'h00;
    end
    // hold until ack sampled low; a released bus shows inverted values
    always @(posedge clk) begin
        if (start && !busy) begin
            {byteStrobe, sysSelect, readNotWrite} <= {1'b1, useSel, rd};
            addr <= a; // callers pass odd byte addresses only
            cpuDataIn <= wd;
            busy <= 1'b1;
            waitCnt <= 0;
        end else if (busy) begin
            waitCnt <= waitCnt + 1;
            // refused accesses give up after a bounded wait
            if (transferAckN === 1'b0 || waitCnt > 100) begin
                rdData <= cpuDataOut;
                {byteStrobe, sysSelect, busy} <= 3'h0;
                addr <= ~addr;
                cpuDataIn <= ~cpuDataIn;
            end
        end
    end
endmodule : apa_cpu_model

/* File: bench/async_to_sync_peripheral_adapter_test.sv */
`timescale 1ns/1ps
module async_to_sync_peripheral_adapter_test;
    import apa_pkg::*;
    logic clk = 0, rst_n = 0, periphEnable = 0, start = 0, rd = 0, useSel = 0, busy;
    logic [23:0] a = 24'h000000, addr;
    logic [7:0] wd = 8'h00, perDataIn = 8'h00, cpuDataIn, cpuDataOut, perDataOut, rdData;
    logic byteStrobe, sysSelect, readNotWrite, cpuDataOe, perDataOe;
    logic transferAckN, periphSelectN, timerSelLowN, timerSelHigh, linkSelN;
    logic [3:0] cnt = 4'h0;
    int mismatches = 0, check_count = 0, cyc = 0, selAt, ackAt;
    logic [7:0] ackPer = 8'h00; // peripheral-side data seen when ack first goes low
    always #2.5 clk = ~clk;
    // enable clock of 16 cycles, free running and unrelated to bus activity
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        periphEnable <= cnt[3];
    end
    apa_cpu_model cpu (.clk(clk), .start(start), .rd(rd), .useSel(useSel), .a(a), .wd(wd),
        .transferAckN(transferAckN), .cpuDataOut(cpuDataOut), .byteStrobe(byteStrobe),
        .sysSelect(sysSelect), .readNotWrite(readNotWrite), .addr(addr),
        .cpuDataIn(cpuDataIn), .rdData(rdData), .busy(busy));
    apa_adapter DUT (.clk(clk), .rst_n(rst_n), .byteStrobe(byteStrobe),
        .sysSelect(sysSelect), .readNotWrite(readNotWrite), .periphEnable(periphEnable),
        .addr(addr), .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe),
        .perDataIn(perDataIn), .perDataOut(perDataOut), .perDataOe(perDataOe),
        .transferAckN(transferAckN), .periphSelectN(periphSelectN),
        .timerSelLowN(timerSelLowN), .timerSelHigh(timerSelHigh), .linkSelN(linkSelN));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // one access via the partner; records when select and ack first go low
    task automatic access(input logic r, input logic s, input logic [23:0] ad, input int at);
        int n;
        while (cnt != at[3:0]) @(posedge clk);
        start <= 1'b1;
        {rd, useSel, a, wd} <= {r, s, ad, ~ad[7:0]};
        @(posedge clk);
        start <= 1'b0;
        selAt = -1;
        ackAt = -1;
        #1; // the partner raises busy on this edge; look only once it has settled
        for (n = 1; n < 200 && busy === 1'b1; n++) begin
            @(posedge clk);
            #1;
            chk(timerSelHigh, !periphSelectN);
            if (!s) chk(cpuDataOe, 1'b0);
            if (periphSelectN === 1'b0 && selAt < 0) selAt = n;
            if (periphSelectN === 1'b0) chk(timerSelLowN, ad != TIMER_BASE);
            if (periphSelectN === 1'b0) chk(linkSelN, ad != LINK_BASE);
            if (transferAckN === 1'b0 && ackAt < 0) begin
                ackAt = n;
                ackPer = perDataOut;
                chk(periphSelectN, 1'b1);
                chk({cpuDataOe, perDataOe}, {r, !r});
            end
        end
        repeat (5) @(posedge clk);
        chk(transferAckN, 1'b1);
    endtask : access
    task automatic t_write_early();
        access(1'b0, 1'b1, LINK_BASE, 10);
        chk(selAt <= 12 && selAt > 0, 1'b1);
        chk(ackAt - selAt inside {[14:18]}, 1'b1);
        chk(ackPer, 8'hFE);
    endtask : t_write_early
    task automatic t_read_late();
        perDataIn <= 8'h3C;
        access(1'b1, 1'b1, TIMER_BASE, 1);
        chk(selAt >= 12, 1'b1);
        chk(rdData, 8'h3C);
    endtask : t_read_late
    task automatic t_refused();
        access(1'b1, 1'b0, LINK_BASE, 4);
        chk(ackAt, -1);
        chk(selAt, -1);
    endtask : t_refused
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk({transferAckN, periphSelectN, perDataOe, cpuDataOe}, 4'hE);
        chk({cpuDataOut, perDataOut}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_write_early();
        t_read_late();
        t_refused();
        t_write_early();
        complete_run();
    end
endmodule : async_to_sync_peripheral_adapter_test
